// >>> rtl/xadl_pkg.sv
// shared types and constants for the xor and direction-load executor
package xadl_pkg;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int DSEL_W  = 3;

	localparam logic [DSEL_W-1:0] DSEL_PORT_A = 3'h5;
	localparam logic [DSEL_W-1:0] DSEL_PORT_B = 3'h6;
	localparam logic [DSEL_W-1:0] DSEL_PORT_C = 3'h7;

	localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
	localparam logic              ZERO_RESET  = 1'b0;
	localparam logic [DATA_W-1:0] DIR_RESET   = 8'hff;
	localparam logic [DATA_W-1:0] ZERO_BYTE   = 8'h00;
	localparam logic              DEST_ACC    = 1'b0;
	localparam logic              DEST_FILE   = 1'b1;

	typedef enum logic [1:0] {
		XADL_OP_NONE    = 2'b00,
		XADL_OP_DIRLOAD = 2'b01,
		XADL_OP_XORIMM  = 2'b10,
		XADL_OP_XORFILE = 2'b11
	} xadl_op_t;

	// one decoded instruction from the decoder
	typedef struct packed {
		logic                valid;
		xadl_op_t            op;
		logic [DATA_W-1:0]   literal;
		logic [FADDR_W-1:0]  faddr;
		logic                dest;
		logic [DSEL_W-1:0]   dsel;
	} xadl_instr_t;

	// file register write-back request
	typedef struct packed {
		logic                we;
		logic [FADDR_W-1:0]  addr;
		logic [DATA_W-1:0]   data;
	} xadl_fwrite_t;
endpackage

// >>> rtl/xadl_xor_unit.sv
// combinational xor datapath with zero detect
`timescale 1ns/1ps
module xadl_xor_unit #(
	parameter int WIDTH = 8
) (
	// operands
	input  wire logic [WIDTH-1:0] a_in,
	input  wire logic [WIDTH-1:0] b_in,
	// result
	output logic      [WIDTH-1:0] result_out,
	output logic                  zero_out
);
	if (WIDTH < 1) begin : g_width_check
		$error("xadl_xor_unit: WIDTH must be positive");
	end

	always_comb begin
		result_out = a_in ^ b_in;
		zero_out   = ~|(a_in ^ b_in);
	end
endmodule

// >>> rtl/xadl_exec.sv
// executes direction-load, xor-immediate and xor-file instructions
// Contract
// - direction-load copies the accumulator to the chosen direction register and leaves flags alone.
// - the direction-load operand 5, 6 or 7 picks port a, b or c; other values do nothing.
// - xor-immediate xors the accumulator with an 8-bit literal into the accumulator, touching only zero.
// - xor-file xors the accumulator with the 7-bit addressed file register, touching only zero.
// - xor-file with destination 0 writes the accumulator and leaves the file register as is.
// - xor-file with destination 1 writes the file register and leaves the accumulator as is.
`timescale 1ns/1ps
module xadl_exec #(
	parameter int DATA_W  = xadl_pkg::DATA_W,
	parameter int FADDR_W = xadl_pkg::FADDR_W
) (
	// clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_n_in,
	// decoded instruction
	input  wire xadl_pkg::xadl_instr_t  instr_in,
	// file register read data for instr_in.faddr, same cycle
	input  wire logic [DATA_W-1:0]      file_rdata_in,
	// file register read address
	output logic      [FADDR_W-1:0]     file_raddr_out,
	// file register write-back
	output xadl_pkg::xadl_fwrite_t      file_wr_out,
	// architectural state
	output logic      [DATA_W-1:0]      acc_out,
	output logic                        zero_flag_out,
	output logic      [DATA_W-1:0]      port_a_direction_out,
	output logic      [DATA_W-1:0]      port_b_direction_out,
	output logic      [DATA_W-1:0]      port_c_direction_out
);
	// carriers are fixed-width structs, so the widths cannot differ
	if (DATA_W != xadl_pkg::DATA_W || FADDR_W != xadl_pkg::FADDR_W)
	begin : g_width_check
		$error("xadl_exec: widths must match package carriers");
	end

	logic [DATA_W-1:0] acc_reg, acc_next;
	logic              zero_reg, zero_next;
	logic [DATA_W-1:0] dir_a_reg, dir_a_next;
	logic [DATA_W-1:0] dir_b_reg, dir_b_next;
	logic [DATA_W-1:0] dir_c_reg, dir_c_next;
	xadl_pkg::xadl_fwrite_t fwr_reg, fwr_next;

	logic [DATA_W-1:0] xor_b;
	logic [DATA_W-1:0] xor_res;
	logic              xor_zero;

	// file read is addressed straight from the operand
	assign file_raddr_out = instr_in.faddr;

	assign xor_b = (instr_in.op == xadl_pkg::XADL_OP_XORFILE) ?
		file_rdata_in : instr_in.literal;

	xadl_xor_unit #(
		.WIDTH (DATA_W)
	) xadl_xor_unit_i (
		.a_in       (acc_reg),
		.b_in       (xor_b),
		.result_out (xor_res),
		.zero_out   (xor_zero)
	);

	always_comb begin
		acc_next    = acc_reg;
		zero_next   = zero_reg;
		dir_a_next  = dir_a_reg;
		dir_b_next  = dir_b_reg;
		dir_c_next  = dir_c_reg;
		fwr_next    = '0;
		if (instr_in.valid) begin
			unique case (instr_in.op)
				xadl_pkg::XADL_OP_NONE: begin
				end
				xadl_pkg::XADL_OP_DIRLOAD: begin
					// operands outside 5..7 are ignored, no latch of junk
					unique case (instr_in.dsel)
						xadl_pkg::DSEL_PORT_A: dir_a_next = acc_reg;
						xadl_pkg::DSEL_PORT_B: dir_b_next = acc_reg;
						xadl_pkg::DSEL_PORT_C: dir_c_next = acc_reg;
						default: begin
						end
					endcase
				end
				xadl_pkg::XADL_OP_XORIMM: begin
					acc_next  = xor_res;
					zero_next = xor_zero;
				end
				xadl_pkg::XADL_OP_XORFILE: begin
					zero_next = xor_zero;
					if (instr_in.dest == xadl_pkg::DEST_ACC) begin
						acc_next = xor_res;
					end else begin
						fwr_next.we   = 1'b1;
						fwr_next.addr = instr_in.faddr;
						fwr_next.data = xor_res;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			acc_reg   <= xadl_pkg::ACC_RESET;
			zero_reg  <= xadl_pkg::ZERO_RESET;
			dir_a_reg <= xadl_pkg::DIR_RESET;
			dir_b_reg <= xadl_pkg::DIR_RESET;
			dir_c_reg <= xadl_pkg::DIR_RESET;
			fwr_reg   <= '0;
		end else begin
			acc_reg   <= acc_next;
			zero_reg  <= zero_next;
			dir_a_reg <= dir_a_next;
			dir_b_reg <= dir_b_next;
			dir_c_reg <= dir_c_next;
			fwr_reg   <= fwr_next;
		end
	end

	assign acc_out              = acc_reg;
	assign zero_flag_out        = zero_reg;
	assign port_a_direction_out = dir_a_reg;
	assign port_b_direction_out = dir_b_reg;
	assign port_c_direction_out = dir_c_reg;
	assign file_wr_out          = fwr_reg;

	// helper decodes for assertions
	logic is_dir, is_ximm, is_xf;
	assign is_dir  = instr_in.valid &&
		instr_in.op == xadl_pkg::XADL_OP_DIRLOAD;
	assign is_ximm = instr_in.valid &&
		instr_in.op == xadl_pkg::XADL_OP_XORIMM;
	assign is_xf   = instr_in.valid &&
		instr_in.op == xadl_pkg::XADL_OP_XORFILE;

	a_dir_flags_kept: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_dir |=> $stable(zero_reg) && $stable(acc_reg))
		else $error("direction load changed accumulator or flag");

	a_dir_port_a: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_dir && instr_in.dsel == xadl_pkg::DSEL_PORT_A |=>
		dir_a_reg == $past(acc_reg) && $stable(dir_b_reg)
		&& $stable(dir_c_reg))
		else $error("port a direction load wrong");

	a_dir_port_sel: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_dir && instr_in.dsel == xadl_pkg::DSEL_PORT_B |=>
		dir_b_reg == $past(acc_reg) && $stable(dir_a_reg)
		&& $stable(dir_c_reg))
		else $error("port b direction load wrong");

	a_dir_port_c: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_dir && instr_in.dsel == xadl_pkg::DSEL_PORT_C |=>
		dir_c_reg == $past(acc_reg) && $stable(dir_a_reg)
		&& $stable(dir_b_reg))
		else $error("port c direction load wrong");

	a_dir_bad_operand: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_dir && instr_in.dsel < xadl_pkg::DSEL_PORT_A |=>
		$stable(dir_a_reg) && $stable(dir_b_reg) && $stable(dir_c_reg))
		else $error("invalid direction operand wrote a port");

	a_ximm_operand: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_ximm |-> xor_b == instr_in.literal)
		else $error("literal xor operand wrong");

	a_ximm_result: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_ximm |=> acc_reg == ($past(acc_reg) ^ $past(instr_in.literal))
		&& !file_wr_out.we)
		else $error("literal xor result wrong");

	a_xf_to_acc: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_xf && instr_in.dest == xadl_pkg::DEST_ACC |=>
		acc_reg == ($past(acc_reg) ^ $past(file_rdata_in))
		&& !file_wr_out.we)
		else $error("file xor to accumulator wrong");

	a_no_stray_write: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!(is_xf && instr_in.dest == xadl_pkg::DEST_FILE) |=>
		!file_wr_out.we)
		else $error("file register written without a file xor");

	a_xf_to_file: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_xf && instr_in.dest == xadl_pkg::DEST_FILE |=>
		file_wr_out.we && file_wr_out.addr == $past(instr_in.faddr)
		&& file_wr_out.data == ($past(acc_reg) ^ $past(file_rdata_in))
		&& $stable(acc_reg))
		else $error("file xor write-back wrong");

	a_xf_read_addr: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		is_xf |-> file_raddr_out == instr_in.faddr
		&& xor_b == file_rdata_in)
		else $error("file read address or operand wrong");

	a_zero_flag: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(is_ximm || is_xf) |=>
		zero_reg == (($past(acc_reg) ^ $past(xor_b))
		== xadl_pkg::ZERO_BYTE))
		else $error("zero flag wrong after xor");

	c_dir_load: cover property (@(posedge sys_clk_in) is_dir);
	c_dir_ignored: cover property (@(posedge sys_clk_in)
		is_dir && instr_in.dsel < xadl_pkg::DSEL_PORT_A);
	c_xor_zero: cover property (@(posedge sys_clk_in) is_ximm && xor_zero);
	c_xf_file: cover property (@(posedge sys_clk_in)
		is_xf && instr_in.dest == xadl_pkg::DEST_FILE);
	c_xf_acc: cover property (@(posedge sys_clk_in)
		is_xf && instr_in.dest == xadl_pkg::DEST_ACC);
endmodule

// >>> sim/test_xadl_exec.sv
// self-checking bench for the xor and direction-load executor
`timescale 1ns/1ps
module test_xadl_exec;
	typedef struct packed {
		xadl_pkg::xadl_op_t op;
		logic [7:0]         lit;
		logic [6:0]         fa;
		logic               dst;
		logic [2:0]         dsel;
		logic [7:0]         acc;
		logic               z;
		logic [23:0]        dir;
		logic               we;
		logic [7:0]         wd;
	} xadl_row_t;

	logic                   sys_clk_in = 1'b0;
	logic                   rst_n_in = 1'b0;
	xadl_pkg::xadl_instr_t  instr_in = '0;
	logic [7:0]             file_rdata_in;
	logic [6:0]             raddr;
	xadl_pkg::xadl_fwrite_t wr;
	logic [7:0]             acc;
	logic                   z;
	logic [7:0]             pa;
	logic [7:0]             pb;
	logic [7:0]             pc;
	logic [7:0]             mem [128];
	int                     err_count = 0;
	int                     checks_done = 0;
	xadl_row_t              rows [12];

	always #4 sys_clk_in = ~sys_clk_in;
	// file memory reads combinationally, writes on the pulse edge
	assign file_rdata_in = mem[raddr];
	always @(posedge sys_clk_in) begin
		if (wr.we === 1'b1) mem[wr.addr] <= wr.data;
	end

	xadl_exec xadl_exec_i (
		.sys_clk_in           (sys_clk_in),
		.rst_n_in             (rst_n_in),
		.instr_in             (instr_in),
		.file_rdata_in        (file_rdata_in),
		.file_raddr_out       (raddr),
		.file_wr_out          (wr),
		.acc_out              (acc),
		.zero_flag_out        (z),
		.port_a_direction_out (pa),
		.port_b_direction_out (pb),
		.port_c_direction_out (pc)
	);

	task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task chk_bit(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task check_state(input xadl_row_t r);
		chk_byte("acc", r.acc, acc);
		chk_bit("zero", r.z, z);
		chk_byte("dir_a", r.dir[23:16], pa);
		chk_byte("dir_b", r.dir[15:8], pb);
		chk_byte("dir_c", r.dir[7:0], pc);
		chk_bit("wr_we", r.we, wr.we);
		if (r.we) chk_byte("wr_data", r.wd, wr.data);
	endtask

	// called at a rising edge; returns just after the taking edge
	task issue(input xadl_row_t r);
		instr_in <= '{1'b1, r.op, r.lit, r.fa, r.dst, r.dsel};
		@(posedge sys_clk_in);
	endtask

	localparam xadl_pkg::xadl_op_t O_NO = xadl_pkg::XADL_OP_NONE;
	localparam xadl_pkg::xadl_op_t O_DL = xadl_pkg::XADL_OP_DIRLOAD;
	localparam xadl_pkg::xadl_op_t O_XI = xadl_pkg::XADL_OP_XORIMM;
	localparam xadl_pkg::xadl_op_t O_XF = xadl_pkg::XADL_OP_XORFILE;

	localparam xadl_row_t RST = '{O_NO, 8'h00, 7'h00, 1'b0, 3'h0,
		8'h00, 1'b0, 24'hffffff, 1'b0, 8'h00};
	// back to back pair: file write, then literal xor reusing acc
	localparam xadl_row_t B2B_IN = '{O_XF, 8'h00, 7'h01, 1'b1, 3'h0,
		8'h00, 1'b0, 24'h000000, 1'b0, 8'h00};
	localparam xadl_row_t B2B_WB = '{O_NO, 8'h00, 7'h00, 1'b0, 3'h0,
		8'h43, 1'b0, 24'ha5003c, 1'b1, 8'h42};
	localparam xadl_row_t B2B_XI = '{O_NO, 8'h00, 7'h00, 1'b0, 3'h0,
		8'h00, 1'b1, 24'ha5003c, 1'b0, 8'h00};

	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'(i);
		// memory holds its own address, so file results are easy to predict
		rows[0]  = '{O_XI, 8'ha5, 7'h00, 1'b0, 3'h0,
			8'ha5, 1'b0, 24'hffffff, 1'b0, 8'h00};
		rows[1]  = '{O_DL, 8'h00, 7'h00, 1'b0, 3'h5,
			8'ha5, 1'b0, 24'ha5ffff, 1'b0, 8'h00};
		rows[2]  = '{O_XI, 8'ha5, 7'h00, 1'b0, 3'h0,
			8'h00, 1'b1, 24'ha5ffff, 1'b0, 8'h00};
		rows[3]  = '{O_DL, 8'h00, 7'h00, 1'b0, 3'h6,
			8'h00, 1'b1, 24'ha500ff, 1'b0, 8'h00};
		rows[4]  = '{O_XI, 8'h3c, 7'h00, 1'b0, 3'h0,
			8'h3c, 1'b0, 24'ha500ff, 1'b0, 8'h00};
		rows[5]  = '{O_DL, 8'h00, 7'h00, 1'b0, 3'h7,
			8'h3c, 1'b0, 24'ha5003c, 1'b0, 8'h00};
		rows[6]  = '{O_DL, 8'h00, 7'h00, 1'b0, 3'h4,
			8'h3c, 1'b0, 24'ha5003c, 1'b0, 8'h00};
		rows[7]  = '{O_XF, 8'h00, 7'h7f, 1'b0, 3'h0,
			8'h43, 1'b0, 24'ha5003c, 1'b0, 8'h00};
		rows[8]  = '{O_XF, 8'h00, 7'h43, 1'b1, 3'h0,
			8'h43, 1'b1, 24'ha5003c, 1'b1, 8'h00};
		rows[9]  = '{O_XF, 8'h00, 7'h00, 1'b0, 3'h0,
			8'h43, 1'b0, 24'ha5003c, 1'b0, 8'h00};
		rows[10] = '{O_XF, 8'h00, 7'h43, 1'b0, 3'h0,
			8'h43, 1'b0, 24'ha5003c, 1'b0, 8'h00};
		rows[11] = '{O_NO, 8'hff, 7'h00, 1'b0, 3'h0,
			8'h43, 1'b0, 24'ha5003c, 1'b0, 8'h00};
		repeat (4) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		#1 check_state(RST);
		$display("reset test done");
		@(posedge sys_clk_in);
		for (int i = 0; i < 12; i++) begin
			issue(rows[i]);
			instr_in.valid <= 1'b0;
			#1 check_state(rows[i]);
			@(posedge sys_clk_in);
		end
		chk_byte("mem_7f", 8'h7f, mem[127]);
		$display("table test done");
		// back to back: the write pulse must drop while acc is reused
		issue(B2B_IN);
		instr_in <= '{1'b1, O_XI, 8'h43, 7'h00, 1'b0, 3'h0};
		#1 check_state(B2B_WB);
		chk_byte("wr_addr", 8'h01, {1'b0, wr.addr});
		@(posedge sys_clk_in);
		instr_in.valid <= 1'b0;
		#1 check_state(B2B_XI);
		chk_byte("mem_01", 8'h42, mem[1]);
		$display("back to back test done");
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		@(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		#1 check_state(RST);
		// first instruction after a mid-run reset must still execute
		@(posedge sys_clk_in);
		issue(rows[0]);
		instr_in.valid <= 1'b0;
		#1 check_state(rows[0]);
		$display("second reset test done");
		final_report();
	end
endmodule
